// ==== host_port_host_model.sv ====
// host processor model driving the host port pins
`timescale 1ns/100ps
module host_port_host_model
    import host_port_pkg::*;
(
    // clock and device outputs
    input  wire logic              clock_i,
    input  wire logic              port_ready_n_i,
    input  wire logic [HALF_W-1:0] bus_i,
    // host pins
    output logic                   port_select_n_o,
    output logic                   strobe_a_n_o,
    output logic                   strobe_b_n_o,
    output access_sel_t            sel_o,
    output logic      [HALF_W-1:0] data_o
);
    initial begin
        port_select_n_o = 1'b1;
        strobe_a_n_o    = 1'b1;
        strobe_b_n_o    = 1'b1;
        sel_o           = '0;
        data_o          = 16'h0000;
    end

    task automatic access(input reg_sel_t rs, input logic rd,
                          input logic hw, input logic [HALF_W-1:0] wd,
                          input logic use_b, input logic both,
                          output logic [HALF_W-1:0] rdata,
                          output logic stalled);
        int n;
        n       = 0;
        stalled = 1'b0;
        @(negedge clock_i);
        sel_o           = {rs, rd, hw};
        data_o          = rd ? ~data_o : wd;
        port_select_n_o = 1'b0;
        @(negedge clock_i);
        strobe_a_n_o = use_b & ~both;
        strobe_b_n_o = ~use_b & ~both;
        // ready only reacts once the fall has crossed the synchronisers;
        // sampled mid-cycle, away from the edge that moves it
        do begin
            @(negedge clock_i);
            n++;
            if (port_ready_n_i !== 1'b0)
                stalled = 1'b1;
        end while ((n < 4 || port_ready_n_i !== 1'b0) && n < 400);
        rdata = bus_i;
        @(negedge clock_i);
        sel_o = ~sel_o;
        @(negedge clock_i);
        strobe_a_n_o    = 1'b1;
        strobe_b_n_o    = 1'b1;
        port_select_n_o = 1'b1;
        @(negedge clock_i);
        data_o = ~data_o;
        repeat (5) @(negedge clock_i);
    endtask
endmodule

// ==== host_port_pkg.sv ====
// constants and types shared by the host port handshake
package host_port_pkg;
    localparam int          HALF_W            = 16;
    localparam int          WORD_W            = 32;
    localparam int          FIFO_DEPTH_DEF    = 8;
    localparam logic [3:0]  ADDR_GAP_CYC      = 4'h4;
    localparam logic [31:0] ADDR_STEP         = 32'h0000_0004;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET        = 32'h0000_0000;
    localparam int          CTRL_READ_CMD_A_BIT = 4;
    localparam int          CTRL_FLUSH_BIT    = 5;

    // selector pair {a,b}
    typedef enum logic [1:0] {
        SEL_CTRL, SEL_DATA_INC, SEL_ADDR, SEL_DATA_FIX
    } reg_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT, ST_READY, ST_HOLD
    } port_state_t;

    typedef struct packed {
        logic reg_selector_a;
        logic reg_selector_b;
        logic read_write_dir;
        logic half_word_indicator;
    } access_sel_t;

    typedef struct packed {
        logic              port_select_n;
        logic              data_strobe_a_n;
        logic              data_strobe_b_n;
        access_sel_t       sel;
        logic [HALF_W-1:0] data;
    } pin_in_t;

    typedef struct packed {
        logic [WORD_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } write_entry_t;
endpackage

// ==== host_port_strobe_ready_handshake.sv ====
// host port strobe, ready and data handshake with read/write fifos
`timescale 1ns/100ps
module host_port_strobe_ready_handshake
    import host_port_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    // host pins
    input  wire logic              port_select_n_i,
    input  wire logic              data_strobe_a_n_i,
    input  wire logic              data_strobe_b_n_i,
    input  wire logic              reg_selector_a_i,
    input  wire logic              reg_selector_b_i,
    input  wire logic              read_write_dir_i,
    input  wire logic              half_word_indicator_i,
    input  wire logic [HALF_W-1:0] host_data_bus_i,
    output logic                   port_ready_n_o,
    output logic      [HALF_W-1:0] host_data_bus_o,
    output logic                   host_data_bus_oe_o,
    // system side write drain
    output logic                   sys_wr_valid_o,
    input  wire logic              sys_wr_ready_i,
    output logic      [WORD_W-1:0] sys_wr_addr_o,
    output logic      [WORD_W-1:0] sys_wr_data_o,
    // system side read fill
    output logic                   sys_rd_req_o,
    output logic      [WORD_W-1:0] sys_rd_addr_o,
    input  wire logic              sys_rd_valid_i,
    input  wire logic [WORD_W-1:0] sys_rd_data_i,
    output logic                   sys_rd_ready_o,
    // stored control word
    output logic      [WORD_W-1:0] ctrl_o
);
    localparam int AW = $clog2(FIFO_DEPTH);

    generate
        if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin : g_chk
            $error("FIFO_DEPTH must be a power of two, at least 2");
        end
    endgenerate

    function automatic logic [HALF_W-1:0] pick_half(
        input logic [WORD_W-1:0] w, input logic second);
        pick_half = second ? w[WORD_W-1:HALF_W] : w[HALF_W-1:0];
    endfunction

    function automatic logic is_data_sel(input reg_sel_t s);
        is_data_sel = (s == SEL_DATA_INC) || (s == SEL_DATA_FIX);
    endfunction

    // pin synchronisers
    pin_in_t pins_1_ff, pins_2_ff;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_1_ff <= '1;
            pins_2_ff <= '1;
        end else begin
            pins_1_ff <= {port_select_n_i, data_strobe_a_n_i,
                          data_strobe_b_n_i, reg_selector_a_i,
                          reg_selector_b_i, read_write_dir_i,
                          half_word_indicator_i, host_data_bus_i};
            pins_2_ff <= pins_1_ff;
        end
    end

    // fifo storage
    write_entry_t      wmem [FIFO_DEPTH];
    logic [WORD_W-1:0] rmem [FIFO_DEPTH];
    logic [AW:0]       wwr_ff, wrd_ff, rwr_ff, rrd_ff;
    logic [AW:0]       nxt_wwr, nxt_wrd, nxt_rwr, nxt_rrd;
    logic [AW:0]       w_cnt, r_cnt;
    logic              w_full, w_empty, r_full, r_empty;
    logic              w_push, w_pop, r_push, r_pop, r_flush;
    write_entry_t      w_entry;

    // control state
    port_state_t       state_ff, nxt_state;
    access_sel_t       acc_ff, nxt_acc;
    logic              strobe_d_ff, nxt_strobe_d;
    logic [WORD_W-1:0] ctrl_ff, nxt_ctrl, addr_ff, nxt_addr;
    logic [WORD_W-1:0] fetch_ff, nxt_fetch, rword_ff, nxt_rword;
    logic [HALF_W-1:0] wlow_ff, nxt_wlow, rdata_ff, nxt_rdata;
    logic [3:0]        gap_ff, nxt_gap;
    logic              pref_ff, nxt_pref, flush_ff, nxt_flush;
    logic              waited_ff, nxt_waited, pref_cmd;
    logic              strobe_n, fall, rise, stall, rd_acc;
    reg_sel_t          sel, sel_now;

    assign w_cnt   = wwr_ff - wrd_ff;
    assign r_cnt   = rwr_ff - rrd_ff;
    assign w_full  = w_cnt == (AW+1)'(FIFO_DEPTH);
    assign w_empty = w_cnt == '0;
    assign r_full  = r_cnt == (AW+1)'(FIFO_DEPTH);
    assign r_empty = r_cnt == '0;

    always_comb begin
        nxt_state    = state_ff;
        nxt_acc      = acc_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_addr     = addr_ff;
        nxt_fetch    = fetch_ff;
        nxt_rword    = rword_ff;
        nxt_wlow     = wlow_ff;
        nxt_rdata    = rdata_ff;
        nxt_gap      = (gap_ff != 4'h0) ? gap_ff - 4'h1 : gap_ff;
        nxt_pref     = pref_ff;
        nxt_flush    = flush_ff & ~w_empty;
        pref_cmd     = 1'b0;
        w_push       = 1'b0;
        r_pop        = 1'b0;
        r_flush      = 1'b0;
        w_entry      = '{addr: addr_ff, data: {pins_2_ff.data, wlow_ff}};
        strobe_n     = ~(pins_2_ff.data_strobe_a_n ^
                         pins_2_ff.data_strobe_b_n) |
                       pins_2_ff.port_select_n;
        nxt_strobe_d = strobe_n;
        fall         = strobe_d_ff & ~strobe_n;
        rise         = ~strobe_d_ff & strobe_n;
        sel          = reg_sel_t'({acc_ff.reg_selector_a,
                                   acc_ff.reg_selector_b});
        sel_now      = reg_sel_t'({pins_2_ff.sel.reg_selector_a,
                                   pins_2_ff.sel.reg_selector_b});
        rd_acc       = acc_ff.read_write_dir;
        // stall decision per access kind
        case (sel)
            SEL_ADDR:
                stall = ~rd_acc & ((gap_ff != 4'h0)
                        | pref_ff | ~w_empty);
            SEL_DATA_INC, SEL_DATA_FIX:
                stall = rd_acc
                      ? (~acc_ff.half_word_indicator & r_empty)
                      : (w_full | flush_ff);
            default:
                stall = 1'b0;
        endcase
        // a read that stalled loads its data before ready falls
        nxt_waited   = (state_ff == ST_WAIT) & stall;
        case (state_ff)
            ST_IDLE: begin
                // preload so ready-at-once reads are valid at once
                case (sel_now)
                    SEL_CTRL: nxt_rdata = pick_half(ctrl_ff,
                                  pins_2_ff.sel.half_word_indicator);
                    SEL_ADDR: nxt_rdata = pick_half(addr_ff,
                                  pins_2_ff.sel.half_word_indicator);
                    default:  nxt_rdata =
                                  pins_2_ff.sel.half_word_indicator
                                  ? pick_half(rword_ff, 1'b1)
                                  : pick_half(rmem[rrd_ff[AW-1:0]], 1'b0);
                endcase
                if (fall) begin
                    nxt_acc   = pins_2_ff.sel;
                    nxt_state = ST_WAIT;
                    if (sel_now == SEL_DATA_FIX &&
                        pins_2_ff.sel.read_write_dir &&
                        !pins_2_ff.sel.half_word_indicator) begin
                        r_flush   = 1'b1;
                        nxt_fetch = addr_ff;
                    end
                end
            end
            ST_WAIT: begin
                if (rise) begin
                    nxt_state = ST_IDLE;
                end else if (!stall) begin
                    nxt_state = ST_READY;
                    if (rd_acc && is_data_sel(sel) &&
                        !acc_ff.half_word_indicator) begin
                        r_pop     = 1'b1;
                        nxt_rword = rmem[rrd_ff[AW-1:0]];
                        nxt_rdata = pick_half(rmem[rrd_ff[AW-1:0]],
                                              1'b0);
                    end
                end
            end
            ST_READY: begin
                if (rise) begin
                    nxt_state = ST_HOLD;
                    if (!rd_acc && !acc_ff.half_word_indicator) begin
                        nxt_wlow = pins_2_ff.data;
                    end else if (!rd_acc) begin
                        case (sel)
                            SEL_CTRL: begin
                                nxt_ctrl = w_entry.data;
                                if (w_entry.data[CTRL_READ_CMD_A_BIT]) begin
                                    pref_cmd = 1'b1;
                                end
                                if (w_entry.data[CTRL_FLUSH_BIT]) begin
                                    nxt_flush = 1'b1;
                                end
                            end
                            SEL_ADDR: begin
                                nxt_addr  = w_entry.data;
                                nxt_fetch = w_entry.data;
                                nxt_gap   = ADDR_GAP_CYC;
                                r_flush   = 1'b1;
                            end
                            default: begin
                                w_push = 1'b1;
                                if (sel == SEL_DATA_INC) begin
                                    nxt_addr = addr_ff + ADDR_STEP;
                                end
                            end
                        endcase
                    end else if (sel == SEL_DATA_INC &&
                                 acc_ff.half_word_indicator) begin
                        nxt_addr = addr_ff + ADDR_STEP;
                    end
                end
            end
            ST_HOLD: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
        // read_cmd_a ends with a delivered word; a new command wins
        r_push = sys_rd_valid_i & ~r_full & ~r_flush;
        if (r_push) begin
            nxt_fetch = fetch_ff + ADDR_STEP;
        end
        nxt_pref = pref_cmd | (pref_ff & ~r_push);
        w_pop   = sys_wr_ready_i & ~w_empty;
        nxt_wwr = w_push ? wwr_ff + 1'b1 : wwr_ff;
        nxt_wrd = w_pop ? wrd_ff + 1'b1 : wrd_ff;
        nxt_rwr = r_flush ? rrd_ff : (r_push ? rwr_ff + 1'b1 : rwr_ff);
        nxt_rrd = (r_pop && !r_flush) ? rrd_ff + 1'b1 : rrd_ff;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff    <= ST_IDLE;
            acc_ff      <= '0;
            strobe_d_ff <= 1'b1;
            ctrl_ff     <= CTRL_RESET;
            addr_ff     <= ADDR_RESET;
            fetch_ff    <= ADDR_RESET;
            rword_ff    <= '0;
            wlow_ff     <= '0;
            rdata_ff    <= '0;
            gap_ff      <= 4'h0;
            pref_ff     <= 1'b0;
            flush_ff    <= 1'b0;
            waited_ff   <= 1'b0;
            wwr_ff      <= '0;
            wrd_ff      <= '0;
            rwr_ff      <= '0;
            rrd_ff      <= '0;
        end else begin
            state_ff    <= nxt_state;
            acc_ff      <= nxt_acc;
            strobe_d_ff <= nxt_strobe_d;
            ctrl_ff     <= nxt_ctrl;
            addr_ff     <= nxt_addr;
            fetch_ff    <= nxt_fetch;
            rword_ff    <= nxt_rword;
            wlow_ff     <= nxt_wlow;
            rdata_ff    <= nxt_rdata;
            gap_ff      <= nxt_gap;
            pref_ff     <= nxt_pref;
            flush_ff    <= nxt_flush;
            waited_ff   <= nxt_waited;
            wwr_ff      <= nxt_wwr;
            wrd_ff      <= nxt_wrd;
            rwr_ff      <= nxt_rwr;
            rrd_ff      <= nxt_rrd;
        end
    end

    always_ff @(posedge clock_i) begin
        if (w_push) begin
            wmem[wwr_ff[AW-1:0]] <= w_entry;
        end
        if (r_push) begin
            rmem[rwr_ff[AW-1:0]] <= sys_rd_data_i;
        end
    end

    assign port_ready_n_o     = ~pins_2_ff.port_select_n &
                                (state_ff == ST_WAIT) &
                                (stall | (waited_ff & rd_acc));
    assign host_data_bus_o    = rdata_ff;
    assign host_data_bus_oe_o = rd_acc & (state_ff != ST_IDLE);
    assign sys_wr_valid_o     = ~w_empty;
    assign sys_wr_addr_o      = wmem[wrd_ff[AW-1:0]].addr;
    assign sys_wr_data_o      = wmem[wrd_ff[AW-1:0]].data;
    assign sys_rd_ready_o     = ~r_full;
    assign sys_rd_addr_o      = fetch_ff;
    assign sys_rd_req_o       = ~r_full & (pref_ff | ((state_ff == ST_WAIT)
                                & rd_acc & is_data_sel(sel)
                                & ~acc_ff.half_word_indicator & r_empty));
    assign ctrl_o             = ctrl_ff;

    sequence s_read_end;
        (state_ff == ST_READY) && rd_acc && rise;
    endsequence
    sequence s_release;
        host_data_bus_oe_o ##1 !host_data_bus_oe_o;
    endsequence

    property p_both_low_ignored;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_IDLE) && !pins_2_ff.data_strobe_a_n &&
        !pins_2_ff.data_strobe_b_n |=> state_ff != ST_WAIT;
    endproperty
    a_both_low_ignored: assert property (p_both_low_ignored)
        else $error("access taken with both data strobes low");

    property p_sel_capture;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_IDLE) && fall |=>
        (state_ff == ST_WAIT) && acc_ff == $past(pins_2_ff.sel);
    endproperty
    a_sel_capture: assert property (p_sel_capture)
        else $error("selects not captured at strobe fall");

    property p_wdata_capture;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_READY) && rise && !rd_acc &&
        !acc_ff.half_word_indicator |=> wlow_ff == $past(pins_2_ff.data);
    endproperty
    a_wdata_capture: assert property (p_wdata_capture)
        else $error("write data not captured at strobe rise");

    property p_addr_gap;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_READY) && rise && !rd_acc && sel == SEL_ADDR &&
        acc_ff.half_word_indicator |=> gap_ff == ADDR_GAP_CYC;
    endproperty
    a_addr_gap: assert property (p_addr_gap)
        else $error("address hold-off not started");

    property p_full_stall;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_WAIT) && !rd_acc && is_data_sel(sel) && w_full &&
        !pins_2_ff.port_select_n |-> port_ready_n_o;
    endproperty
    a_full_stall: assert property (p_full_stall)
        else $error("data write not stalled on full fifo");

    property p_empty_stall;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_WAIT) && rd_acc && is_data_sel(sel) &&
        !acc_ff.half_word_indicator && r_empty && !rise
        |=> state_ff == ST_WAIT;
    endproperty
    a_empty_stall: assert property (p_empty_stall)
        else $error("read left wait with empty read fifo");

    property p_reg_read_fast;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_WAIT) && rd_acc && !is_data_sel(sel) && !rise
        |=> state_ff == ST_READY;
    endproperty
    a_reg_read_fast: assert property (p_reg_read_fast)
        else $error("register read did not go ready at once");

    property p_read_data_ready;
        @(posedge clock_i) disable iff (!resetn_i)
        (state_ff == ST_WAIT) && rd_acc && stall && !rise &&
        !pins_2_ff.port_select_n
        |=> port_ready_n_o || pins_2_ff.port_select_n;
    endproperty
    a_read_data_ready: assert property (p_read_data_ready)
        else $error("ready fell before stalled read data was loaded");

    property p_release;
        @(posedge clock_i) disable iff (!resetn_i)
        s_read_end |=> s_release;
    endproperty
    a_release: assert property (p_release)
        else $error("read bus not held then released");

    property p_fifo_bound;
        @(posedge clock_i) disable iff (!resetn_i)
        w_cnt <= (AW+1)'(FIFO_DEPTH) && r_cnt <= (AW+1)'(FIFO_DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo count beyond depth");

    property p_autoinc;
        @(posedge clock_i) disable iff (!resetn_i)
        s_read_end ##0 (sel == SEL_DATA_INC && acc_ff.half_word_indicator)
        |=> addr_ff == $past(addr_ff) + ADDR_STEP;
    endproperty
    a_autoinc: assert property (p_autoinc)
        else $error("address not incremented after data read");
endmodule

// ==== test_host_port_strobe_ready_handshake.sv ====
// self-checking bench for the host port handshake
`timescale 1ns/100ps
module test_host_port_strobe_ready_handshake;
    import host_port_pkg::*;

    typedef struct packed {
        reg_sel_t    rs;
        logic        rd;
        logic        hw;
        logic [15:0] wd;
        logic [15:0] er;
        logic [1:0]  es;
    } row_t;

    logic              clock_i  = 1'b0;
    logic              resetn_i = 1'b0;
    logic              sel_n, stb_a_n, stb_b_n, ready_n, oe, stalled;
    access_sel_t       sel;
    logic [HALF_W-1:0] hdata, dout, bus, rdata;
    logic              wr_valid, rd_req, rd_ready;
    logic              wr_ready = 1'b1;
    logic              rd_valid = 1'b0;
    logic [1:0]        rd_dly   = 2'd0;
    logic [WORD_W-1:0] rd_data  = 32'h0000_0000;
    logic [WORD_W-1:0] wr_addr, wr_data, rd_addr, ctrl, last_wa, last_wd;
    int                fail_count = 0;
    int                num_checks = 0;
    int                pops       = 0;
    int                oe_cyc     = 0;
    int                n;

    row_t rows [0:19] = '{
        '{SEL_CTRL,     1'b0, 1'b0, 16'hA00F, 16'h0000, 2'd0},
        '{SEL_CTRL,     1'b0, 1'b1, 16'h5A5A, 16'h0000, 2'd0},
        '{SEL_CTRL,     1'b1, 1'b0, 16'h0000, 16'hA00F, 2'd0},
        '{SEL_CTRL,     1'b1, 1'b1, 16'h0000, 16'h5A5A, 2'd0},
        '{SEL_ADDR,     1'b0, 1'b0, 16'h0100, 16'h0000, 2'd2},
        '{SEL_ADDR,     1'b0, 1'b1, 16'h0000, 16'h0000, 2'd2},
        '{SEL_ADDR,     1'b1, 1'b0, 16'h0000, 16'h0100, 2'd0},
        '{SEL_ADDR,     1'b1, 1'b1, 16'h0000, 16'h0000, 2'd0},
        '{SEL_DATA_FIX, 1'b0, 1'b0, 16'hBEEF, 16'h0000, 2'd0},
        '{SEL_DATA_FIX, 1'b0, 1'b1, 16'hDEAD, 16'h0000, 2'd0},
        '{SEL_DATA_FIX, 1'b1, 1'b0, 16'h0000, 16'h0100, 2'd1},
        '{SEL_DATA_FIX, 1'b1, 1'b1, 16'h0000, 16'hC1DE, 2'd0},
        '{SEL_DATA_INC, 1'b0, 1'b0, 16'h1111, 16'h0000, 2'd0},
        '{SEL_DATA_INC, 1'b0, 1'b1, 16'h2222, 16'h0000, 2'd0},
        '{SEL_ADDR,     1'b1, 1'b0, 16'h0000, 16'h0104, 2'd0},
        '{SEL_CTRL,     1'b0, 1'b0, 16'h0010, 16'h0000, 2'd0},
        '{SEL_CTRL,     1'b0, 1'b1, 16'h0000, 16'h0000, 2'd0},
        '{SEL_DATA_INC, 1'b1, 1'b0, 16'h0000, 16'h0104, 2'd0},
        '{SEL_DATA_INC, 1'b1, 1'b1, 16'h0000, 16'hC1DA, 2'd0},
        '{SEL_ADDR,     1'b1, 1'b0, 16'h0000, 16'h0108, 2'd0}
    };

    always #25 clock_i = ~clock_i;
    assign bus = oe ? dout : hdata;

    host_port_strobe_ready_handshake #(.FIFO_DEPTH(FIFO_DEPTH_DEF)) dut (
        .clock_i(clock_i), .resetn_i(resetn_i),
        .port_select_n_i(sel_n), .data_strobe_a_n_i(stb_a_n),
        .data_strobe_b_n_i(stb_b_n),
        .reg_selector_a_i(sel.reg_selector_a),
        .reg_selector_b_i(sel.reg_selector_b),
        .read_write_dir_i(sel.read_write_dir),
        .half_word_indicator_i(sel.half_word_indicator),
        .host_data_bus_i(bus), .port_ready_n_o(ready_n),
        .host_data_bus_o(dout), .host_data_bus_oe_o(oe),
        .sys_wr_valid_o(wr_valid), .sys_wr_ready_i(wr_ready),
        .sys_wr_addr_o(wr_addr), .sys_wr_data_o(wr_data),
        .sys_rd_req_o(rd_req), .sys_rd_addr_o(rd_addr),
        .sys_rd_valid_i(rd_valid), .sys_rd_data_i(rd_data),
        .sys_rd_ready_o(rd_ready), .ctrl_o(ctrl)
    );

    host_port_host_model host (
        .clock_i(clock_i), .port_ready_n_i(ready_n), .bus_i(bus),
        .port_select_n_o(sel_n), .strobe_a_n_o(stb_a_n),
        .strobe_b_n_o(stb_b_n), .sel_o(sel), .data_o(hdata)
    );

    // system memory answers with a word derived from its address
    function automatic logic [WORD_W-1:0] pat(input logic [WORD_W-1:0] a);
        return {a[15:0] ^ 16'hC0DE, a[15:0]};
    endfunction

    always @(posedge clock_i) begin
        if (oe === 1'b1)
            oe_cyc++;
        if (resetn_i && wr_valid === 1'b1 && wr_ready) begin
            pops++;
            last_wa = wr_addr;
            last_wd = wr_data;
        end
    end

    always @(negedge clock_i) begin
        rd_dly   <= (rd_req === 1'b1) ? rd_dly + 2'd1 : 2'd0;
        rd_valid <= (rd_req === 1'b1) && (rd_dly == 2'd2) && rd_ready;
        rd_data  <= (rd_dly == 2'd2) ? pat(rd_addr) : ~rd_data;
    end

    task automatic check(input logic [WORD_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic release_wr;
        repeat (30) @(negedge clock_i);
        wr_ready = 1'b1;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        check(ready_n, 1'b0);
        for (int i = 0; i < 20; i++) begin
            if (i == 17)
                repeat (40) @(negedge clock_i);
            host.access(rows[i].rs, rows[i].rd, rows[i].hw, rows[i].wd,
                        i[0], 1'b0, rdata, stalled);
            if (rows[i].rd)
                check(rdata, rows[i].er);
            if (rows[i].es != 2'd2)
                check(stalled, rows[i].es[0]);
            check(oe, 1'b0);
            $display("row %0d done", i);
        end
        check(pops, 2);
        check(last_wa, 32'h0000_0100);
        check(last_wd, 32'h2222_1111);
        wr_ready = 1'b0;
        for (int k = 0; k < 21; k++) begin
            if (k == 2 * FIFO_DEPTH_DEF || k == 20)
                fork
                    release_wr();
                join_none
            if (k < 20)
                host.access(SEL_DATA_FIX, 1'b0, k[0], 16'h1000, 1'b0, 1'b0,
                            rdata, stalled);
            else
                host.access(SEL_ADDR, 1'b0, 1'b0, 16'h0100, 1'b0, 1'b0,
                            rdata, stalled);
            check(stalled, k == 2 * FIFO_DEPTH_DEF || k == 20);
            if (k == 17)
                wr_ready = 1'b0;
        end
        check(pops, 12);
        check(last_wa, 32'h0000_0108);
        check(last_wd, 32'h1000_1000);
        $display("fifo tests done");
        n = oe_cyc;
        host.access(SEL_CTRL, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b1,
                    rdata, stalled);
        check(oe_cyc - n, 0);
        check(stalled, 1'b0);
        $display("strobe test done");
        resetn_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check({ready_n, oe, wr_valid, rd_req}, 4'h0);
        check(ctrl, CTRL_RESET);
        resetn_i = 1'b1;
        host.access(SEL_ADDR, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0,
                    rdata, stalled);
        check(rdata, ADDR_RESET[15:0]);
        $display("reset test done");
        complete_run();
    end

    initial begin
        repeat (6000) @(posedge clock_i);
        fail_count++;
        complete_run();
    end
endmodule
